// >>> flash_access_command_sequencer.sv
// flash access command sequencer with user-mode reset release
`timescale 1ns/10ps
`default_nettype none

module flash_access_command_sequencer (
   input  wire logic                  core_clk_i,      // 40 MHz core clock
   input  wire logic                  arst_n_i,        // async reset, active low
   input  wire logic                  init_done_n_i,   // config done, low in user mode
   input  wire logic                  force_factory_i, // pin: boot factory image
   input  wire logic                  as_x4_boot_i,    // pin: booted in x4 active serial
   input  wire logic                  cmd_valid_i,     // mailbox command present
   input  wire logic [3:0]            cmd_code_i,      // command code
   input  wire logic [1:0]            cmd_client_i,    // issuing host identity
   input  wire logic [31:0]           cmd_addr_i,      // flash byte address
   input  wire logic [31:0]           cmd_data_i,      // write data or chip select
   output logic                       cmd_ready_o,     // command taken when high
   output logic                       rsp_valid_o,     // one-cycle response pulse
   output logic [2:0]                 rsp_code_o,      // response code
   output logic [31:0]                rsp_data_o,      // read data or status
   output logic                       user_rst_n_o,    // released user reset
   output logic                       reconfig_o,      // one-cycle reconfigure request
   output logic                       flash_req_o,     // flash operation request
   output logic [3:0]                 flash_op_o,      // flash operation code
   output logic [1:0]                 flash_cs_o,      // selected flash chip
   output logic [31:0]                flash_addr_o,    // flash byte address
   output logic [31:0]                flash_wdata_o,   // flash write data
   output logic [3:0]                 flash_dummy_o,   // dummy clocks before data
   input  wire logic                  flash_done_i,    // flash operation finished
   input  wire logic [31:0]           flash_rdata_i    // flash read data
);

   // ---------------------------------------------------------------
   // reset release synchroniser
   // ---------------------------------------------------------------
   logic rst_s1_reg;   // first stage, read only by second
   logic rst_s2_reg;   // second stage, user mode reset released
   wire  rst_gate_n;   // synchroniser reset, held while not in user mode

   assign rst_gate_n = arst_n_i & ~init_done_n_i;

   always_ff @(posedge core_clk_i or negedge rst_gate_n) begin
      if (!rst_gate_n) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   assign user_rst_n_o = rst_s2_reg;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] factory_sync_reg;   // force factory pin, two stages
   logic [1:0] x4_sync_reg;        // x4 boot pin, two stages

   // two flops on each strap pin before use
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         factory_sync_reg <= 2'h 0;
         x4_sync_reg      <= 2'h 0;
      end else begin
         factory_sync_reg <= {factory_sync_reg[0], force_factory_i};
         x4_sync_reg      <= {x4_sync_reg[0], as_x4_boot_i};
      end
   end

   // ---------------------------------------------------------------
   // state and decode
   // ---------------------------------------------------------------
   flash_seq_pkg::state_e state_reg;       // sequencer state
   flash_seq_pkg::state_e state_next;      // next state
   logic                  boot_done_reg;   // boot image captured
   logic [31:0]           cur_image_reg;   // running image start address
   logic                  lock_reg;        // flash interface reserved
   logic [1:0]            owner_reg;       // host holding the interface
   logic                  cs_set_reg;      // chip select given since open
   logic [1:0]            cs_reg;          // selected chip

   wire accept;        // command taken this cycle
   wire owner_ok;      // issuer holds the interface
   wire cs_ok;         // chip select satisfied
   wire is_flash_cmd;  // command needs the flash
   wire go_flash;      // start a flash operation
   wire [2:0] chk_code; // response code for every accepted command
   wire [31:0] boot_addr; // image chosen at boot

   assign accept = cmd_valid_i & cmd_ready_o & (state_reg == flash_seq_pkg::ST_IDLE);

   // only the opener may use the interface
   assign owner_ok = lock_reg & (owner_reg == cmd_client_i);

   // chip select mandatory outside x4 boot
   assign cs_ok = x4_sync_reg[1] | cs_set_reg;

   assign is_flash_cmd = (cmd_code_i >= flash_seq_pkg::CMD_READ) &&
                         (cmd_code_i <= flash_seq_pkg::CMD_RAW_OP);

   assign go_flash = is_flash_cmd & owner_ok & cs_ok;

   // response code for every command path
   assign chk_code =
      (cmd_code_i == flash_seq_pkg::CMD_STATUS) ? flash_seq_pkg::RSP_OK :
      (cmd_code_i == flash_seq_pkg::CMD_OPEN) ?
         ((lock_reg & ~owner_ok) ? flash_seq_pkg::RSP_BUSY : flash_seq_pkg::RSP_OK) :
      ((cmd_code_i == flash_seq_pkg::CMD_CLOSE) || (cmd_code_i == flash_seq_pkg::CMD_SET_CS)) ?
         (owner_ok ? flash_seq_pkg::RSP_OK : flash_seq_pkg::RSP_NOT_OWNER) :
      (is_flash_cmd || (cmd_code_i == flash_seq_pkg::CMD_IMAGE_UPDATE)) ?
         (!owner_ok ? flash_seq_pkg::RSP_NOT_OWNER :
          !cs_ok    ? flash_seq_pkg::RSP_NO_CS : flash_seq_pkg::RSP_OK) :
      flash_seq_pkg::RSP_BAD_CMD;

   assign boot_addr = factory_sync_reg[1] ? flash_seq_pkg::FACTORY_IMAGE_ADDR :
                                            flash_seq_pkg::APP_IMAGE1_ADDR;

   // next state selection
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         flash_seq_pkg::ST_IDLE: begin
            if (accept) begin
               state_next = go_flash ? flash_seq_pkg::ST_FLASH : flash_seq_pkg::ST_RESP;
            end
         end
         flash_seq_pkg::ST_FLASH: begin
            if (flash_done_i) begin
               state_next = flash_seq_pkg::ST_RESP;
            end
         end
         flash_seq_pkg::ST_RESP: begin
            state_next = flash_seq_pkg::ST_IDLE;
         end
         default: begin
            state_next = flash_seq_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer state and ownership
   // ---------------------------------------------------------------
   // held idle until user mode
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg     <= flash_seq_pkg::ST_IDLE;
         boot_done_reg <= 1'b0;
         cur_image_reg <= 32'h 0000_0000;
         cmd_ready_o   <= 1'b0;
      end else if (!rst_s2_reg) begin
         state_reg     <= flash_seq_pkg::ST_IDLE;
         boot_done_reg <= 1'b0;
         cmd_ready_o   <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cmd_ready_o <= boot_done_reg & (state_next == flash_seq_pkg::ST_IDLE);
         // capture the boot image once after release
         if (!boot_done_reg) begin
            boot_done_reg <= 1'b1;
            cur_image_reg <= boot_addr;
         end else if (accept && (cmd_code_i == flash_seq_pkg::CMD_IMAGE_UPDATE) &&
                      (chk_code == flash_seq_pkg::RSP_OK)) begin
            cur_image_reg <= cmd_addr_i;
         end
      end
   end

   // reservation held from open to close or image update
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lock_reg   <= 1'b0;
         owner_reg  <= 2'h 0;
         cs_set_reg <= 1'b0;
         cs_reg     <= 2'h 0;
      end else if (!rst_s2_reg) begin
         lock_reg   <= 1'b0;
         cs_set_reg <= 1'b0;
      end else if (accept && (chk_code == flash_seq_pkg::RSP_OK)) begin
         unique case (cmd_code_i)
            flash_seq_pkg::CMD_OPEN: begin
               lock_reg   <= 1'b1;
               owner_reg  <= cmd_client_i;
               cs_set_reg <= 1'b0;
            end
            flash_seq_pkg::CMD_CLOSE: begin
               lock_reg   <= 1'b0;
               cs_set_reg <= 1'b0;
            end
            flash_seq_pkg::CMD_SET_CS: begin
               cs_set_reg <= 1'b1;
               cs_reg     <= cmd_data_i[1:0];
            end
            // reconfiguration drops the reservation
            flash_seq_pkg::CMD_IMAGE_UPDATE: begin
               lock_reg   <= 1'b0;
               cs_set_reg <= 1'b0;
            end
            default: begin
               lock_reg <= lock_reg;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // flash request and responses
   // ---------------------------------------------------------------
   // flash request held until done, response pulse one cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flash_req_o   <= 1'b0;
         flash_op_o    <= 4'h 0;
         flash_cs_o    <= 2'h 0;
         flash_addr_o  <= 32'h 0000_0000;
         flash_wdata_o <= 32'h 0000_0000;
         flash_dummy_o <= 4'h 0;
         rsp_valid_o   <= 1'b0;
         rsp_code_o    <= 3'h 0;
         rsp_data_o    <= 32'h 0000_0000;
         reconfig_o    <= 1'b0;
      end else begin
         rsp_valid_o <= (state_next == flash_seq_pkg::ST_RESP) & rst_s2_reg;
         reconfig_o  <= accept & (cmd_code_i == flash_seq_pkg::CMD_IMAGE_UPDATE) &
                        (chk_code == flash_seq_pkg::RSP_OK);
         if (accept) begin
            rsp_code_o <= chk_code;
            rsp_data_o <= (cmd_code_i == flash_seq_pkg::CMD_STATUS) ? cur_image_reg :
                                                                     32'h 0000_0000;
         end
         if (accept && go_flash) begin
            flash_req_o   <= 1'b1;
            flash_op_o    <= cmd_code_i;
            flash_cs_o    <= cs_reg;
            flash_addr_o  <= cmd_addr_i;
            flash_wdata_o <= cmd_data_i;
            flash_dummy_o <= (cmd_code_i == flash_seq_pkg::CMD_READ) ?
                             flash_seq_pkg::FAST_READ_DUMMY : flash_seq_pkg::NO_DUMMY;
         end else if ((state_reg == flash_seq_pkg::ST_FLASH) && flash_done_i) begin
            flash_req_o <= 1'b0;
            rsp_data_o  <= flash_rdata_i;
         end
      end
   end

endmodule : flash_access_command_sequencer

`default_nettype wire

// >>> flash_access_command_sequencer_asserts.sv
// port assertions for the flash access command sequencer
`timescale 1ns/10ps
`default_nettype none

module flash_access_command_sequencer_asserts (
   input wire logic        core_clk_i,
   input wire logic        arst_n_i,
   input wire logic        init_done_n_i,
   input wire logic        cmd_valid_i,
   input wire logic [3:0]  cmd_code_i,
   input wire logic        cmd_ready_o,
   input wire logic        rsp_valid_o,
   input wire logic [2:0]  rsp_code_o,
   input wire logic        user_rst_n_o,
   input wire logic        reconfig_o,
   input wire logic        flash_req_o,
   input wire logic [3:0]  flash_op_o,
   input wire logic [31:0] flash_addr_o,
   input wire logic [3:0]  flash_dummy_o,
   input wire logic        flash_done_i
);
   // ---------------------------------------------------------------
   // shared timing
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   wire take = cmd_valid_i && cmd_ready_o;  // command accepted this edge
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_hold_rst; init_done_n_i |-> !user_rst_n_o; endproperty
   a_hold_rst: assert property (p_hold_rst) else $error("user reset left early");
   property p_two_stage; $rose(user_rst_n_o) |-> !init_done_n_i && !$past(init_done_n_i);
   endproperty
   a_two_stage: assert property (p_two_stage) else $error("reset not two stage");
   property p_idle_rst; !user_rst_n_o |-> !cmd_ready_o && !flash_req_o && !rsp_valid_o;
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("active while in reset");
   property p_dummy; flash_req_o |-> flash_dummy_o == ((flash_op_o == 4'h3) ?
      flash_seq_pkg::FAST_READ_DUMMY : flash_seq_pkg::NO_DUMMY); endproperty
   a_dummy: assert property (p_dummy) else $error("wrong dummy count");
   property p_req_hold; flash_req_o && !flash_done_i |=> flash_req_o && $stable(flash_addr_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("flash request dropped");
   property p_done_rsp; flash_req_o && flash_done_i |=> rsp_valid_o && !flash_req_o;
   endproperty
   a_done_rsp: assert property (p_done_rsp) else $error("no response after done");
   property p_busy; take |=> !cmd_ready_o; endproperty
   a_busy: assert property (p_busy) else $error("ready after take");
   property p_status; take && cmd_code_i == 4'hb |=> rsp_valid_o &&
      rsp_code_o == flash_seq_pkg::RSP_OK; endproperty
   a_status: assert property (p_status) else $error("status not answered");
   property p_reconfig; reconfig_o |-> rsp_valid_o && rsp_code_o == flash_seq_pkg::RSP_OK
      ##1 !reconfig_o; endproperty
   a_reconfig: assert property (p_reconfig) else $error("bad reconfigure pulse");
   // ---------------------------------------------------------------
   // coverage of main scenarios
   // ---------------------------------------------------------------
   c_read: cover property (flash_req_o && flash_op_o == 4'h3 && flash_done_i);
   c_reconfig: cover property (reconfig_o);
   c_refused: cover property (rsp_valid_o && rsp_code_o != flash_seq_pkg::RSP_OK);
endmodule : flash_access_command_sequencer_asserts
`default_nettype wire

// >>> flash_access_command_sequencer_tb_top.sv
// testbench for the flash access command sequencer
`timescale 1ns/10ps
`default_nettype none

module flash_access_command_sequencer_tb_top;
   logic clk = 1'b0, arst_n = 1'b0, init_n = 1'b1, x4 = 1'b0, valid = 1'b0, ff = 1'b0;
   logic [3:0] code = 4'h0, lat = 4'h0, fop, fdum;
   logic [1:0] who = 2'h0, fcs;
   logic [31:0] addr = 32'h0000_0000, data = 32'h0000_0000, rdat, fa, wd, rd_w;
   logic ready, rv, user_n, recfg, req, done, seen;
   logic [2:0] rc_w, rc;
   logic [31:0] rd;
   int n_errors = 0, tests_run = 0, cyc = 0;
   localparam logic [2:0] OK = flash_seq_pkg::RSP_OK;
   localparam logic [2:0] NOWN = flash_seq_pkg::RSP_NOT_OWNER;

   flash_access_command_sequencer u_flash_access_command_sequencer (
      .core_clk_i(clk), .arst_n_i(arst_n), .init_done_n_i(init_n), .force_factory_i(ff),
      .as_x4_boot_i(x4), .cmd_valid_i(valid), .cmd_code_i(code), .cmd_client_i(who),
      .cmd_addr_i(addr), .cmd_data_i(data), .cmd_ready_o(ready), .rsp_valid_o(rv),
      .rsp_code_o(rc_w), .rsp_data_o(rd_w), .user_rst_n_o(user_n), .reconfig_o(recfg),
      .flash_req_o(req), .flash_op_o(fop), .flash_cs_o(fcs), .flash_addr_o(fa),
      .flash_wdata_o(wd), .flash_dummy_o(fdum), .flash_done_i(done), .flash_rdata_i(rdat));
   flash_side_model u_flash_side_model (.core_clk_i(clk), .arst_n_i(arst_n), .req_i(req),
      .addr_i(fa), .lat_i(lat), .done_o(done), .rdata_o(rdat));

   // clock and hang guard
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check

   // one command: hold until taken, then wait for its answer
   task automatic send(input logic [3:0] c, input logic [1:0] w, input logic [31:0] a,
                       input logic [3:0] l, input logic [2:0] exp);
      int n;
      n = 0;
      @(posedge clk);
      valid <= 1'b1; code <= c; who <= w; addr <= a; data <= 32'h0000_0001; lat <= l;
      do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 200);
      @(posedge clk);
      valid <= 1'b0;
      seen = 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         seen |= recfg;
      end while (rv !== 1'b1 && n < 200);
      rc = rc_w;
      rd = rd_w;
      check(rv === 1'b1 && rc === exp, "wrong response code");
   endtask : send

   task automatic t_boot();
      send(flash_seq_pkg::CMD_STATUS, 2'h1, 32'h0000_0000, 4'h0, OK);
      check(rd === flash_seq_pkg::APP_IMAGE1_ADDR, "boot image address");
      $display("test boot finished");
   endtask : t_boot

   task automatic t_lock();
      send(flash_seq_pkg::CMD_READ, 2'h1, 32'h0000_0000, 4'h0, NOWN);
      send(flash_seq_pkg::CMD_OPEN, 2'h1, 32'h0000_0000, 4'h0, OK);
      send(flash_seq_pkg::CMD_READ, 2'h1, 32'h0000_0000, 4'h0, flash_seq_pkg::RSP_NO_CS);
      send(flash_seq_pkg::CMD_OPEN, 2'h2, 32'h0000_0000, 4'h0, flash_seq_pkg::RSP_BUSY);
      send(flash_seq_pkg::CMD_SET_CS, 2'h2, 32'h0000_0000, 4'h0, NOWN);
      send(flash_seq_pkg::CMD_CLOSE, 2'h2, 32'h0000_0000, 4'h0, NOWN);
      send(flash_seq_pkg::CMD_SET_CS, 2'h1, 32'h0000_0000, 4'h0, OK);
      send(4'hc, 2'h1, 32'h0000_0000, 4'h0, flash_seq_pkg::RSP_BAD_CMD);
      $display("test lock finished");
   endtask : t_lock

   task automatic t_ops();
      logic [31:0] a;
      for (int i = 3; i <= 8; i++) begin
         a = flash_seq_pkg::POINTER_BLOCK_COPY0_ADDR + 32'(i * 4);
         send(4'(i), 2'h1, a, 4'(i - 3), OK);
         check(rd === ~a, "returned data");
         check(fdum === ((i == 3) ? 4'hf : 4'h0), "dummy clocks");
         check(fop === 4'(i) && fa === a, "operation code or address");
         check(wd === 32'h0000_0001 && fcs === 2'h1, "write data or chip");
      end
      send(flash_seq_pkg::CMD_CLOSE, 2'h1, 32'h0000_0000, 4'h0, OK);
      send(flash_seq_pkg::CMD_OPEN, 2'h2, 32'h0000_0000, 4'h0, OK);
      send(flash_seq_pkg::CMD_CLOSE, 2'h2, 32'h0000_0000, 4'h0, OK);
      $display("test operations finished");
   endtask : t_ops

   task automatic t_update();
      @(posedge clk);
      x4 <= 1'b1;
      repeat (4) @(posedge clk);
      send(flash_seq_pkg::CMD_OPEN, 2'h2, 32'h0000_0000, 4'h0, OK);
      send(flash_seq_pkg::CMD_WRITE, 2'h2, flash_seq_pkg::POINTER_BLOCK_COPY1_ADDR, 4'h2, OK);
      send(flash_seq_pkg::CMD_IMAGE_UPDATE, 2'h2, flash_seq_pkg::FACTORY_IMAGE_ADDR, 4'h0, OK);
      check(seen === 1'b1, "no reconfigure pulse");
      send(flash_seq_pkg::CMD_STATUS, 2'h0, 32'h0000_0000, 4'h0, OK);
      check(rd === flash_seq_pkg::FACTORY_IMAGE_ADDR, "running image address");
      $display("test update finished");
   endtask : t_update

   // second reset in mid-run with the factory pin high
   task automatic t_factory();
      @(posedge clk);
      arst_n <= 1'b0;
      init_n <= 1'b1;
      ff     <= 1'b1;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check(user_n === 1'b0, "user reset left before config done");
      init_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(user_n === 1'b1, "user reset not released");
      send(flash_seq_pkg::CMD_STATUS, 2'h3, 32'h0000_0000, 4'h0, OK);
      check(rd === flash_seq_pkg::FACTORY_IMAGE_ADDR, "factory boot address");
      $display("test factory boot finished");
   endtask : t_factory

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // reset, release into user mode, then the scenarios
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge clk);
      check(user_n === 1'b0, "user reset released early");
      init_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(user_n === 1'b1, "user reset not released");
      t_boot();
      t_lock();
      t_ops();
      t_update();
      t_factory();
      give_verdict();
   end
endmodule : flash_access_command_sequencer_tb_top

bind flash_access_command_sequencer flash_access_command_sequencer_asserts u_chk (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .init_done_n_i(init_done_n_i),
   .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o),
   .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o), .user_rst_n_o(user_rst_n_o),
   .reconfig_o(reconfig_o), .flash_req_o(flash_req_o), .flash_op_o(flash_op_o),
   .flash_addr_o(flash_addr_o), .flash_dummy_o(flash_dummy_o), .flash_done_i(flash_done_i));
`default_nettype wire

// >>> flash_seq_pkg.sv
// constants, command codes and states for the flash access command sequencer
package flash_seq_pkg;

   // ---------------------------------------------------------------
   // flash partition start addresses (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [31:0] FACTORY_IMAGE_ADDR       = 32'h0011_0000;
   localparam logic [31:0] POINTER_BLOCK_COPY0_ADDR = 32'h002E_4000;
   localparam logic [31:0] POINTER_BLOCK_COPY1_ADDR = 32'h002E_C000;
   localparam logic [31:0] APP_IMAGE1_ADDR          = 32'h002F_4000;

   // ---------------------------------------------------------------
   // widths and timing
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 32;   // flash byte address width
   localparam int          DATA_W          = 32;   // mailbox word width
   localparam int          CLIENT_W        = 2;    // host identity width
   localparam int          CS_W            = 2;    // flash chip select field width
   localparam logic [3:0]  FAST_READ_DUMMY = 4'h f; // dummy clocks for fast read
   localparam logic [3:0]  NO_DUMMY        = 4'h 0; // other operations

   // ---------------------------------------------------------------
   // mailbox command codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_OPEN          = 4'h 1,
      CMD_SET_CS        = 4'h 2,
      CMD_READ          = 4'h 3,
      CMD_WRITE         = 4'h 4,
      CMD_ERASE         = 4'h 5,
      CMD_READ_DEV_REG  = 4'h 6,
      CMD_WRITE_DEV_REG = 4'h 7,
      CMD_RAW_OP        = 4'h 8,
      CMD_IMAGE_UPDATE  = 4'h 9,
      CMD_CLOSE         = 4'h a,
      CMD_STATUS        = 4'h b
   } cmd_e;

   // ---------------------------------------------------------------
   // response codes
   // ---------------------------------------------------------------
   localparam logic [2:0] RSP_OK        = 3'h 0; // done
   localparam logic [2:0] RSP_BUSY      = 3'h 1; // interface held by another host
   localparam logic [2:0] RSP_NOT_OWNER = 3'h 2; // interface not opened by this host
   localparam logic [2:0] RSP_NO_CS     = 3'h 3; // chip select needed first
   localparam logic [2:0] RSP_BAD_CMD   = 3'h 4; // unknown command code

   // ---------------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FLASH = 3'b010,
      ST_RESP  = 3'b100
   } state_e;

endpackage : flash_seq_pkg

// >>> flash_side_model.sv
// behavioural flash side answering sequencer operations
`timescale 1ns/10ps
`default_nettype none

module flash_side_model (
   input  wire logic        core_clk_i,  // core clock
   input  wire logic        arst_n_i,    // async reset, active low
   input  wire logic        req_i,       // operation requested
   input  wire logic [31:0] addr_i,      // byte address
   input  wire logic [3:0]  lat_i,       // wait cycles before done
   output logic             done_o,      // one-cycle completion
   output logic [31:0]      rdata_o      // returned word
);
   logic [3:0] wait_reg;                  // cycles spent on this request
   wire        fire = req_i && !done_o && (wait_reg == lat_i);  // finish now
   // answer after lat_i cycles; data toggles when not valid
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_reg <= 4'h0;
         done_o   <= 1'b0;
         rdata_o  <= 32'h0000_0000;
      end else begin
         done_o   <= fire;
         wait_reg <= (req_i && !done_o) ? wait_reg + 4'h1 : 4'h0;
         rdata_o  <= fire ? ~addr_i : ~rdata_o;
      end
   end
endmodule : flash_side_model
`default_nettype wire
